// >>> verilog/msm_cfg.svh
// Purpose: Constants for the status and operating-mode register bank
// Assumes: APB byte addresses, 32-bit words
// Notes on behaviour
// [RL1] Set receive-done flag when reception posts
// [RL2] Underflow sets flag, suspends transmit
// [RL3] Link-pass set on link test or autoneg
// [RL4] Link-pass cleared by link-fail; gated meaning
// [RL5] Jabber timeout sets flag, stops transmit
// [RL6] Host-owned descriptor sets unavailable, suspends transmit
// [RL7] Host resumes by ownership then poll
// [RL8] Transmit-done needs completion bit in descriptor
// [RL9] Bus error type code in bits 25:23
// [RL10] Transmit state code in bits 22:20
// [RL11] Receive state code in bits 19:17
// [RL12] Write one clears flags; state bits read-only
// [RL13] Accept-all receives every packet
// [RL14] Software programs mode bit 25 to one
// [RL15] Whitening and symbol mode port controls
// [RL16] Ten-meg threshold select, change when stopped
// [RL17] Store-forward waits for whole packet
// [RL18] Port choice cleared by hardware reset only
// [RL19] Threshold field picks one of four levels
// [RL20] Run bit starts fetch, may suspend
// [RL21] Clearing run stops after current frame
// [RL22] Force collision in internal loopback
// [RL23] Loopback select encodes normal, internal, external
`ifndef MSM_CFG_SVH
`define MSM_CFG_SVH
`define MSM_OFS_OPCTL       8'h30
`define MSM_OFS_STATUS      8'h28
`define MSM_STATUS_RESET    32'hf0000000
`define MSM_OPCTL_RESET     32'h32000040
`define MSM_OPCTL_HW_MASK   32'hfffbffff
`define MSM_W1C_MASK        32'h0c01ffff
`define MSM_BIT_TX_DONE     0
`define MSM_BIT_TX_STOP     1
`define MSM_BIT_TX_UNAVAIL  2
`define MSM_BIT_JABBER      3
`define MSM_BIT_LINK_PASS   4
`define MSM_BIT_UNDERFLOW   5
`define MSM_BIT_RX_DONE     6
`define MSM_BIT_LINK_FAIL   12
`define MSM_BIT_FATAL       13
`define MSM_BIT_ACCEPT_ALL  30
`define MSM_BIT_WHITEN      24
`define MSM_BIT_SYMBOL      23
`define MSM_BIT_TEN_MEG     22
`define MSM_BIT_STORE_FWD   21
`define MSM_BIT_PORT_CHOICE 18
`define MSM_BIT_TX_RUN      13
`define MSM_BIT_FORCE_COLL  12
`define MSM_ANEG_DONE_CODE  3'h5
`endif

// >>> verilog/msm_pkg.sv
// Purpose: Types for the status and operating-mode register bank
// Assumes: Nothing
// Notes: Codes follow the state fields
package msm_pkg;
  typedef enum logic [2:0] {
    MSM_TX_STOPPED = 3'h0, MSM_TX_FETCH = 3'h1, MSM_TX_WAIT_END = 3'h2, MSM_TX_READ_BUF = 3'h3,
    MSM_TX_SETUP = 3'h5, MSM_TX_SUSPENDED = 3'h6, MSM_TX_CLOSE = 3'h7
  } msm_tx_state_t;
  typedef enum logic [1:0] {
    MSM_LOOP_NORMAL = 2'h0, MSM_LOOP_INTERNAL = 2'h1, MSM_LOOP_EXTERNAL = 2'h2
  } msm_loop_t;
  typedef enum logic [2:0] {
    MSM_BUS_PARITY = 3'h0, MSM_BUS_MASTER_ABORT = 3'h1, MSM_BUS_TARGET_ABORT = 3'h2
  } msm_bus_err_t;
endpackage

// >>> verilog/msm_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Clock enable freezes state
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module msm_sync #(parameter int W = 1)
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] stage1;
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      stage1 <= '0;
      q      <= '0;
    end
    else if (clk_en)
    begin
      stage1 <= d;
      q      <= stage1;
    end
endmodule // msm_sync
`default_nettype wire

// >>> verilog/msm_tx_ctrl.sv
// Purpose: Transmit process state keeper
// Assumes: Events synchronised to core_clk
// Notes: Produces state code and flag pulses
`timescale 1ns/1ps
`default_nettype none
`include "msm_cfg.svh"
module msm_tx_ctrl
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   soft_reset,
  input  wire logic                   tx_run_command,
  input  wire logic                   desc_host_owned,
  input  wire logic                   desc_fetched,
  input  wire logic                   frame_end,
  input  wire logic                   underflow_evt,
  input  wire logic                   jabber_evt,
  input  wire logic                   poll_demand,
  output msm_pkg::msm_tx_state_t      tx_state,
  output var  logic                   unavail_pulse,
  output var  logic                   stopped_pulse,
  output var  logic                   save_position
);
  import msm_pkg::*;
  msm_tx_state_t next_tx_state;
  logic          stop_pending;
  logic          run_d;

  always_comb
  begin
    next_tx_state = tx_state;
    unique case (tx_state)
      MSM_TX_STOPPED:
        if (tx_run_command && !run_d)
          next_tx_state = MSM_TX_FETCH; // [RL20]
      MSM_TX_FETCH:
        if (desc_host_owned)
          next_tx_state = MSM_TX_SUSPENDED; // [RL6]
        else if (desc_fetched)
          next_tx_state = MSM_TX_READ_BUF;
      MSM_TX_READ_BUF:
        next_tx_state = MSM_TX_WAIT_END;
      MSM_TX_WAIT_END:
        if (frame_end)
          next_tx_state = MSM_TX_CLOSE;
      MSM_TX_SETUP:
        next_tx_state = MSM_TX_CLOSE;
      MSM_TX_SUSPENDED:
        if (!tx_run_command)
          next_tx_state = MSM_TX_STOPPED; // [RL21]
        else if (poll_demand)
          next_tx_state = MSM_TX_FETCH;
      MSM_TX_CLOSE:
        next_tx_state = (stop_pending || !tx_run_command) ? MSM_TX_STOPPED : MSM_TX_FETCH; // [RL21]
    endcase
    if (underflow_evt && tx_state != MSM_TX_STOPPED)
      next_tx_state = MSM_TX_SUSPENDED; // [RL2]
    if (jabber_evt)
      next_tx_state = MSM_TX_STOPPED; // [RL5]
    if (soft_reset)
      next_tx_state = MSM_TX_STOPPED;
  end

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      tx_state <= MSM_TX_STOPPED;
    else if (clk_en)
      tx_state <= next_tx_state;

  // Start only on setting the run bit, so a jabber stop does not restart
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      run_d <= 1'b0;
    else if (clk_en)
      run_d <= tx_run_command; // [RL20]

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      stop_pending <= 1'b0;
    else if (clk_en)
      stop_pending <= (next_tx_state == MSM_TX_STOPPED) ? 1'b0 : (stop_pending | ~tx_run_command);

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      unavail_pulse <= 1'b0;
      stopped_pulse <= 1'b0;
      save_position <= 1'b0;
    end
    else if (clk_en)
    begin
      unavail_pulse <= tx_state == MSM_TX_FETCH && next_tx_state == MSM_TX_SUSPENDED && desc_host_owned; // [RL6]
      stopped_pulse <= tx_state != MSM_TX_STOPPED && next_tx_state == MSM_TX_STOPPED;
      save_position <= tx_state != MSM_TX_STOPPED && next_tx_state == MSM_TX_STOPPED; // [RL21]
    end
endmodule // msm_tx_ctrl
`default_nettype wire

// >>> verilog/msm_regs.sv
// Purpose: Event status and operating control registers over APB
// Assumes: Event inputs are single-cycle pulses from core_clk logic; link pins asynchronous
// Notes: Zero wait states; unmapped addresses read zero with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "msm_cfg.svh"
module msm_regs
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire logic                 soft_reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 rx_frame_posted,
  input  wire logic [2:0]           rx_state,
  input  wire logic                 tx_underflow_evt,
  input  wire logic                 jabber_evt,
  input  wire logic                 desc_host_owned,
  input  wire logic                 desc_fetched,
  input  wire logic                 frame_end,
  input  wire logic                 completion_req,
  input  wire logic                 poll_demand,
  input  wire logic                 bus_error_evt,
  input  wire msm_pkg::msm_bus_err_t bus_error_type,
  input  wire logic                 link_test_pin,
  input  wire logic                 link_fail_pin,
  input  wire logic                 autoneg_enable,
  input  wire logic                 link_test_disable_wr,
  input  wire logic [2:0]           autoneg_state,
  input  wire logic                 rx_squelch_enable,
  output var  logic                 accept_all,
  output var  logic                 whitening_enable,
  output var  logic                 symbol_mode,
  output var  logic                 ten_meg_threshold,
  output var  logic                 store_forward,
  output var  logic                 port_choice,
  output var  logic [1:0]           tx_fifo_level,
  output var  logic                 collision_test_force,
  output msm_pkg::msm_loop_t        loopback_select,
  output var  logic                 tx_desc_underflow_mark,
  output var  logic                 tx_desc_jabber_mark,
  output var  logic                 tx_save_position,
  output var  logic                 link_pass_valid
);
  import msm_pkg::*;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [31:0]   event_status;
  logic [31:0]   operating_control;
  logic [2:0]    bus_err_code;
  logic [1:0]    link_sync;
  logic          link_test_d;
  logic [2:0]    aneg_d;
  msm_tx_state_t tx_state;
  logic          unavail_pulse;
  logic          stopped_pulse;
  logic          save_position;
  logic          wr_access;
  logic          wr_status;
  logic          wr_opctl;
  logic          link_pass_evt;
  logic          tx_stopped;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_access = psel && penable && pwrite && clk_en;
  assign wr_status = wr_access && hit(paddr, `MSM_OFS_STATUS);
  assign wr_opctl  = wr_access && hit(paddr, `MSM_OFS_OPCTL);
  assign tx_stopped = (tx_state == MSM_TX_STOPPED);

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit(paddr, `MSM_OFS_STATUS) && !hit(paddr, `MSM_OFS_OPCTL);
      if (hit(paddr, `MSM_OFS_STATUS))
        prdata <= {event_status[31:26], bus_err_code, tx_state, rx_state, event_status[16:0]}; // [RL9] [RL10] [RL11]
      else if (hit(paddr, `MSM_OFS_OPCTL))
        prdata <= operating_control;
      else
        prdata <= 32'h0;
    end

  // ****************************************************************
  // Transmit process
  // ****************************************************************
  msm_tx_ctrl u_tx
  (
    .core_clk        (core_clk),
    .reset           (reset),
    .clk_en          (clk_en),
    .soft_reset      (soft_reset),
    .tx_run_command  (operating_control[`MSM_BIT_TX_RUN]),
    .desc_host_owned (desc_host_owned),
    .desc_fetched    (desc_fetched),
    .frame_end       (frame_end),
    .underflow_evt   (tx_underflow_evt),
    .jabber_evt      (jabber_evt),
    .poll_demand     (poll_demand),
    .tx_state        (tx_state),
    .unavail_pulse   (unavail_pulse),
    .stopped_pulse   (stopped_pulse),
    .save_position   (save_position)
  );

  // ****************************************************************
  // Link detection
  // ****************************************************************
  msm_sync #(.W(2)) u_link_sync
  (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .d        ({link_fail_pin, link_test_pin}),
    .q        (link_sync)
  );

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      link_test_d <= 1'b0;
      aneg_d      <= 3'h0;
    end
    else if (clk_en)
    begin
      link_test_d <= link_sync[0];
      aneg_d      <= autoneg_state;
    end

  assign link_pass_evt = autoneg_enable
    ? (autoneg_state == `MSM_ANEG_DONE_CODE && aneg_d != `MSM_ANEG_DONE_CODE)
    : ((link_sync[0] && !link_test_d) || link_test_disable_wr); // [RL3]

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      link_pass_valid <= 1'b0;
    else if (clk_en)
      link_pass_valid <= !operating_control[`MSM_BIT_PORT_CHOICE] && rx_squelch_enable; // [RL4]

  // ****************************************************************
  // Event status
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      event_status <= `MSM_STATUS_RESET;
    else if (clk_en)
    begin
      if (soft_reset)
        event_status <= `MSM_STATUS_RESET;
      else
      begin
        event_status <= (wr_status ? (event_status & ~(pwdata & `MSM_W1C_MASK)) : event_status) // [RL12]
          | (32'(rx_frame_posted) << `MSM_BIT_RX_DONE) // [RL1]
          | (32'(tx_underflow_evt && !tx_stopped) << `MSM_BIT_UNDERFLOW) // [RL2]
          | (32'(link_pass_evt) << `MSM_BIT_LINK_PASS) // [RL3]
          | (32'(link_sync[1]) << `MSM_BIT_LINK_FAIL)
          | (32'(jabber_evt) << `MSM_BIT_JABBER) // [RL5]
          | (32'(unavail_pulse) << `MSM_BIT_TX_UNAVAIL) // [RL6]
          | (32'(stopped_pulse) << `MSM_BIT_TX_STOP)
          | (32'(frame_end && completion_req) << `MSM_BIT_TX_DONE) // [RL8]
          | (32'(bus_error_evt) << `MSM_BIT_FATAL);
        if (link_sync[1] && !link_pass_evt)
          event_status[`MSM_BIT_LINK_PASS] <= 1'b0; // [RL4]
      end
    end

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      bus_err_code <= 3'h0;
    else if (clk_en)
    begin
      if (soft_reset)
        bus_err_code <= 3'h0; // [RL9]
      else if (bus_error_evt && !event_status[`MSM_BIT_FATAL])
        bus_err_code <= bus_error_type; // [RL9]
    end

  // ****************************************************************
  // Operating control
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      operating_control <= `MSM_OPCTL_RESET; // [RL18]
    else if (clk_en)
    begin
      if (soft_reset)
        operating_control <= (`MSM_OPCTL_RESET & `MSM_OPCTL_HW_MASK)
          | (operating_control & ~`MSM_OPCTL_HW_MASK); // [RL18]
      else if (wr_opctl)
      begin
        operating_control <= pwdata; // [RL13] [RL15] [RL23]
        if (!tx_stopped)
        begin
          operating_control[`MSM_BIT_TEN_MEG]        <= operating_control[`MSM_BIT_TEN_MEG]; // [RL16]
          operating_control[`MSM_BIT_STORE_FWD]      <= operating_control[`MSM_BIT_STORE_FWD]; // [RL17]
          operating_control[15:14]                   <= operating_control[15:14]; // [RL19]
          operating_control[`MSM_BIT_FORCE_COLL]     <= operating_control[`MSM_BIT_FORCE_COLL];
          operating_control[11:10]                   <= operating_control[11:10];
        end
      end
    end

  // ****************************************************************
  // Mode outputs
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      accept_all           <= 1'b0;
      whitening_enable     <= 1'b0;
      symbol_mode          <= 1'b0;
      ten_meg_threshold    <= 1'b0;
      store_forward        <= 1'b0;
      port_choice          <= 1'b0;
      tx_fifo_level        <= 2'h0;
      collision_test_force <= 1'b0;
      loopback_select      <= MSM_LOOP_NORMAL;
    end
    else if (clk_en)
    begin
      accept_all           <= operating_control[`MSM_BIT_ACCEPT_ALL]; // [RL13]
      whitening_enable     <= operating_control[`MSM_BIT_WHITEN]; // [RL15]
      symbol_mode          <= operating_control[`MSM_BIT_SYMBOL]; // [RL15]
      ten_meg_threshold    <= operating_control[`MSM_BIT_TEN_MEG]; // [RL16]
      store_forward        <= operating_control[`MSM_BIT_STORE_FWD]; // [RL17]
      port_choice          <= operating_control[`MSM_BIT_PORT_CHOICE]; // [RL18]
      tx_fifo_level        <= operating_control[15:14]; // [RL19]
      collision_test_force <= operating_control[`MSM_BIT_FORCE_COLL]
        && operating_control[11:10] == MSM_LOOP_INTERNAL; // [RL22]
      loopback_select      <= msm_loop_t'(operating_control[11:10]); // [RL23]
    end

  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      tx_desc_underflow_mark <= 1'b0;
      tx_desc_jabber_mark    <= 1'b0;
      tx_save_position       <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_desc_underflow_mark <= tx_underflow_evt && !tx_stopped; // [RL2]
      tx_desc_jabber_mark    <= jabber_evt; // [RL5]
      tx_save_position       <= save_position; // [RL21]
    end
endmodule // msm_regs
`default_nettype wire

// >>> verification/msm_regs_props.sv
// Purpose: Port assertions for the status and control bank
// Assumes: clk_en held high by the bench
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "msm_cfg.svh"
module msm_regs_props
(
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               clk_en,
  input wire logic               soft_reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               rx_frame_posted,
  input wire logic               tx_underflow_evt,
  input wire logic               jabber_evt,
  input wire logic               port_choice,
  input wire logic               collision_test_force,
  input wire msm_pkg::msm_loop_t loopback_select,
  input wire logic               tx_desc_underflow_mark,
  input wire logic               tx_desc_jabber_mark,
  input wire logic               link_pass_valid
);
  import msm_pkg::*;
  // ************
  // Checks
  // ************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ready_next: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == (paddr != `MSM_OFS_STATUS && paddr != `MSM_OFS_OPCTL))
    else $error("error response wrong");
  a_rx_seen: assert property (pready && !pwrite && paddr == `MSM_OFS_STATUS && $past(rx_frame_posted, 2) |-> prdata[6])
    else $error("receive done not read back");
  a_coll_gate: assert property (collision_test_force |-> loopback_select == MSM_LOOP_INTERNAL)
    else $error("forced collision outside internal loopback");
  a_link_gate: assert property (port_choice [*2] |-> !link_pass_valid)
    else $error("link pass valid with port choice set");
  a_unf_mark: assert property (tx_desc_underflow_mark |-> $past(tx_underflow_evt) || $past(tx_underflow_evt, 2))
    else $error("underflow mark without event");
  a_jab_mark: assert property (tx_desc_jabber_mark |-> $past(jabber_evt) || $past(jabber_evt, 2))
    else $error("jabber mark without event");
  a_port_keep: assert property (soft_reset && !pready && !$past(pready) |=> $stable(port_choice))
    else $error("soft reset changed port choice");
endmodule // msm_regs_props
`default_nettype wire

// >>> verification/msm_host.sv
// Purpose: Host driver model speaking APB to the bank
// Assumes: Tasks entered just after a rising edge
// Notes: Waits on pready without a limit; the bench cuts hangs
`timescale 1ns/1ps
`default_nettype none
`include "msm_cfg.svh"
module msm_host
(
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic        poll_demand
);
  // ************
  // Bus cycles
  // ************
  initial
  begin
    {psel, penable, pwrite, poll_demand} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    if (w && a == `MSM_OFS_OPCTL)
      d[25] = 1'b1;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Ownership handed back by the caller first
  task automatic resume();
    poll_demand <= 1'b1;
    @(posedge core_clk);
    poll_demand <= 1'b0;
  endtask
endmodule // msm_host
`default_nettype wire

// >>> verification/msm_regs_tb.sv
// Purpose: Self-checking bench for the status and control bank
// Assumes: 20 MHz clock, clk_en tied high
// Notes: Events pulsed through one vector
`timescale 1ns/1ps
`default_nettype none
`include "msm_cfg.svh"
module msm_regs_tb;
  import msm_pkg::*;
  localparam logic [7:0] STS = `MSM_OFS_STATUS;
  localparam logic [7:0] OC = `MSM_OFS_OPCTL;
  logic core_clk, reset, clk_en, soft_reset, psel, penable, pwrite, pready, pslverr, poll_demand;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [6:0] ev;
  logic rx_frame_posted, tx_underflow_evt, jabber_evt, desc_fetched, frame_end, bus_error_evt;
  logic link_test_disable_wr, desc_host_owned, completion_req, link_test_pin, link_fail_pin;
  logic autoneg_enable, rx_squelch_enable, e;
  logic unf_seen = 1'b0, jab_seen = 1'b0;
  logic [2:0] rx_state, autoneg_state;
  msm_bus_err_t bus_error_type;
  logic accept_all, whitening_enable, symbol_mode, ten_meg_threshold, store_forward, port_choice;
  logic collision_test_force, tx_desc_underflow_mark, tx_desc_jabber_mark, tx_save_position;
  logic link_pass_valid;
  logic [1:0] tx_fifo_level;
  msm_loop_t loopback_select;
  int mismatches, check_count;
  int cycles = 0, save_cnt = 0;
  assign {rx_frame_posted, tx_underflow_evt, jabber_evt, desc_fetched, frame_end, bus_error_evt,
          link_test_disable_wr} = ev;
  msm_regs i_dut (.*);
  msm_host i_host (.*);
  // ************
  // Helpers
  // ************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (tx_desc_underflow_mark === 1'b1)
      unf_seen <= 1'b1;
    if (tx_desc_jabber_mark === 1'b1)
      jab_seen <= 1'b1;
    if (tx_save_position === 1'b1)
      save_cnt <= save_cnt + 1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input int k);
    ev <= 7'h1 << k;
    wt(1);
    ev <= 7'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_host.xfer(1'b1, a, v, q, e);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_events();
    rd(STS);
    chk(q, 32'hf0000000);
    rd(OC);
    chk(q, 32'h32000040);
    rd(8'h2c);
    chk({q[30:0], e}, 32'h1);
    pulse(6);
    rd(STS);
    chk(q, 32'hf0000040);
    wr(STS, 32'h0);
    rd(STS);
    chk(q, 32'hf0000040);
    wr(STS, 32'hffffffff);
    rd(STS);
    chk(q, 32'hf0000000);
    for (int i = 0; i < 8; i++)
    begin
      rx_state <= 3'(i);
      wt(2);
      rd(STS);
      chk(32'(q[19:17]), 32'(i));
    end
    rx_state <= 3'h0;
    for (int c = 0; c < 3; c++)
    begin
      bus_error_type <= msm_bus_err_t'(c);
      pulse(1);
      rd(STS);
      chk(32'({q[25:23], q[13]}), 32'({3'(c), 1'b1}));
      wr(STS, 32'h2000);
    end
  endtask
  task automatic t_link();
    link_test_pin <= 1'b1;
    wt(4);
    rd(STS);
    chk(32'(q[4]), 32'h1);
    wr(STS, 32'h10);
    pulse(0);
    rd(STS);
    chk(32'(q[4]), 32'h1);
    link_fail_pin <= 1'b1;
    wt(4);
    rd(STS);
    chk(32'({q[12], q[4]}), 32'h2);
    link_fail_pin <= 1'b0;
    wt(4);
    wr(STS, 32'h1010);
    autoneg_enable <= 1'b1;
    autoneg_state <= 3'h5;
    wt(4);
    rd(STS);
    chk(32'({q[4], link_pass_valid}), 32'h3);
    wr(STS, 32'h10);
  endtask
  task automatic t_mode();
    for (int i = 0; i < 4; i++)
    begin
      d = 32'h02001000 | (32'(i) << 14) | (32'(i % 3) << 10) | {1'b0, i[0], 5'h0, i[1], i[0], i[1], i[0], 21'h0};
      wr(OC, d);
      wt(2);
      chk(32'({accept_all, whitening_enable, symbol_mode, ten_meg_threshold, store_forward}),
          32'({i[0], i[1], i[0], i[1], i[0]}));
      chk(32'({tx_fifo_level, loopback_select, collision_test_force}),
          32'({2'(i), 2'(i % 3), i % 3 == 1}));
    end
    wr(OC, 32'h02000000);
  endtask
  task automatic t_tx();
    int n;
    desc_host_owned <= 1'b1;
    wr(OC, 32'h02002000);
    pulse(3);
    wt(2);
    rd(STS);
    chk(32'({q[22:20], q[2]}), 32'hd);
    wr(STS, 32'hffffffff);
    wr(OC, 32'h02402000);
    wt(2);
    rd(STS);
    chk(32'({q[22:20], q[2], ten_meg_threshold}), 32'h18);
    desc_host_owned <= 1'b0;
    i_host.resume();
    pulse(3);
    wt(2);
    rd(STS);
    chk(32'(q[22:20]), 32'h2);
    completion_req <= 1'b1;
    pulse(2);
    completion_req <= 1'b0;
    rd(STS);
    chk(32'(q[0]), 32'h1);
    wr(STS, 32'h1);
    pulse(2);
    rd(STS);
    chk(32'(q[0]), 32'h0);
    pulse(5);
    wt(2);
    rd(STS);
    chk(32'({q[22:20], q[5], unf_seen}), 32'h1b);
    i_host.resume();
    wt(1);
    pulse(4);
    wt(2);
    rd(STS);
    chk(32'({q[22:20], q[3], q[1], jab_seen}), 32'h7);
    wr(OC, 32'h02000000);
    desc_host_owned <= 1'b1;
    wr(OC, 32'h02002000);
    n = save_cnt;
    wr(OC, 32'h02000000);
    wt(3);
    rd(STS);
    chk(32'({q[22:20], save_cnt == n + 1}), 32'h1);
    desc_host_owned <= 1'b0;
  endtask
  task automatic t_port();
    wr(OC, 32'h02040000);
    wt(2);
    chk(32'({port_choice, link_pass_valid}), 32'h2);
    soft_reset <= 1'b1;
    wt(1);
    soft_reset <= 1'b0;
    wt(2);
    rd(OC);
    chk({q[31:1], port_choice}, 32'h32040041);
    reset <= 1'b1;
    wt(1);
    reset <= 1'b0;
    wt(2);
    chk(32'(port_choice), 32'h0);
  endtask
  initial
  begin
    {soft_reset, ev, desc_host_owned, completion_req, link_test_pin, link_fail_pin} = '0;
    {autoneg_enable, rx_state, autoneg_state} = '0;
    {mismatches, check_count} = '0;
    bus_error_type = MSM_BUS_PARITY;
    rx_squelch_enable = 1'b1;
    clk_en = 1'b1;
    reset = 1'b1;
    wt(8);
    reset <= 1'b0;
    wt(1);
    fork
      begin
        t_events();
        t_link();
        t_mode();
        t_tx();
        t_port();
      end
      begin
        wait (cycles >= 5000);
        mismatches++;
      end
    join_any
    final_report();
  end
endmodule // msm_regs_tb
bind msm_regs msm_regs_props i_props (.*);
`default_nettype wire
